// File: mgmt_station_model.sv
// Station manager model issuing register writes
`timescale 1ns/100ps
module mgmt_station_model (
    // Clock
    input wire logic clk,
    // Write port toward the register
    output logic mgmt_wr,
    output logic [4:0] mgmt_devad,
    output logic [15:0] mgmt_addr,
    output logic [15:0] mgmt_wdata,
    input wire logic [15:0] rdata_q
);
    // ----
    // Writes
    // ----
    initial begin
        mgmt_wr = 1'b0;
        mgmt_devad = 5'h00;
        mgmt_addr = 16'h0000;
        mgmt_wdata = 16'h0000;
    end
    // One-cycle strobe; released lines show inverted data
    task automatic wr(input logic [4:0] dv, input logic [15:0] d);
        @(posedge clk);
        #1 mgmt_wr = 1'b1;
        mgmt_devad = dv;
        mgmt_addr = 16'hfff8;
        mgmt_wdata = d;
        @(posedge clk);
        #1 mgmt_wr = 1'b0;
        mgmt_wdata = ~d;
    endtask : wr
    // Reserved bits written back as read
    task automatic rmw(input logic [15:0] v);
        wr(5'h07, (rdata_q & 16'h05e8) | (v & ~16'h05e8));
    endtask : rmw
endmodule : mgmt_station_model

// File: misc_ctrl_pkg.sv
// Package for the shadowed miscellaneous control register
package misc_ctrl_pkg;
    // ------------------------------------------------------------
    // Register location
    // ------------------------------------------------------------
    localparam logic [4:0] DEVAD_MISC = 5'h07;
    localparam logic [15:0] ADDR_SHADOW = 16'hfff8;
    localparam logic [2:0] SEL_AUX = 3'h0;
    localparam logic [2:0] SEL_PWR = 3'h2;
    localparam logic [2:0] SEL_TEST = 3'h4;
    localparam logic [2:0] SEL_MISC = 3'h7;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int WR_EN_BIT = 15;
    localparam logic [2:0] RD_SEL_RST = 3'h0;
    localparam logic [2:0] WR_SEL_RST = 3'h7;
    localparam logic [3:0] ATTEMPT_BASE = 4'h2;
    // Read selector codes
    typedef enum logic [2:0] {
        RD_NORMAL = 3'b000,
        RD_RSVD1 = 3'b001,
        RD_POWER = 3'b010,
        RD_RSVD3 = 3'b011,
        RD_TEST = 3'b100,
        RD_RSVD5 = 3'b101,
        RD_RSVD6 = 3'b110,
        RD_MISC = 3'b111
    } rd_sel_e;
    // Register image, bit 15 down to bit 0
    typedef struct packed {
        logic wr_en;
        rd_sel_e rd_sel;
        logic pkt_rx;
        logic rsvd10;
        logic mdix_force;
        logic [2:0] rsvd8_6;
        logic rsvd5;
        logic downshift_en;
        logic rsvd3;
        logic [2:0] shadow_sel;
    } misc_ctrl_s;
    localparam misc_ctrl_s CTRL_RST = '{wr_en: 1'b0, rd_sel: RD_NORMAL,
        pkt_rx: 1'b0, rsvd10: 1'b0, mdix_force: 1'b0, rsvd8_6: 3'h0,
        rsvd5: 1'b0, downshift_en: 1'b0, rsvd3: 1'b0, shadow_sel: SEL_MISC};
endpackage : misc_ctrl_pkg

// File: shadowed_phy_misc_control.sv
// Shadowed miscellaneous control register with its downshift logic
//
// Operation
// - A write with bit 15 set also loads bits 11 to 3.
// - A write with bit 15 clear loads only bits 14:12 and 2:0.
// - Bit 15 never holds a one: it clears itself and resets to 0.
// - The read selector in bits 14:12 is always writable.
// - Read selector codes are 000, 010, 100, 111; it resets to 000.
// - Bit 11 set counts receive packets, clear counts transmit ones.
// - With auto-negotiation off, bit 9 decides if auto crossover runs.
// - Bit 4 set counts failed links up to 2..9 then downshifts.
// - Bit 4 clear keeps the configured abilities, never reduced.
// - The low three written bits choose which shadow takes the rest.
// - Shadow select codes 000,010,100,111; the field resets to 111.
`timescale 1ns/100ps
module shadowed_phy_misc_control
    import misc_ctrl_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Management write and read port
    input wire logic mgmt_wr,
    input wire logic [4:0] mgmt_devad,
    input wire logic [15:0] mgmt_addr,
    input wire logic [15:0] mgmt_wdata,
    output logic [15:0] rdata_q,
    output logic [2:0] wr_sel_q,
    // Controls to the rest of the PHY
    output logic [2:0] rd_sel_q,
    output logic pkt_rx_q,
    output logic mdix_run_q,
    // Link status and downshift
    input wire logic an_enabled,
    input wire logic an_mdix,
    input wire logic link_fail,
    input wire logic link_up,
    input wire logic [2:0] attempt_code,
    output logic adv_reduced_q,
    output logic retry_q
);
    // ------------------------------------------------------------
    // Register write decode
    // ------------------------------------------------------------
    // Reserved bits are stored so a read-modify-write gets them back
    misc_ctrl_s ctrl_q, ctrl_d, wdata;
    logic [2:0] wr_sel_d;
    logic hit;

    assign wdata = misc_ctrl_s'(mgmt_wdata);
    assign hit = mgmt_wr && mgmt_devad == DEVAD_MISC
        && mgmt_addr == ADDR_SHADOW;

    // Next register image
    always_comb begin
        ctrl_d = ctrl_q;
        wr_sel_d = wr_sel_q;
        if (hit) begin
            wr_sel_d = wdata.shadow_sel;
            if (wdata.shadow_sel == SEL_MISC) begin
                ctrl_d.rd_sel = wdata.rd_sel;
                if (wdata.wr_en) begin
                    ctrl_d.pkt_rx = wdata.pkt_rx;
                    ctrl_d.rsvd10 = wdata.rsvd10;
                    ctrl_d.mdix_force = wdata.mdix_force;
                    ctrl_d.rsvd8_6 = wdata.rsvd8_6;
                    ctrl_d.rsvd5 = wdata.rsvd5;
                    ctrl_d.downshift_en = wdata.downshift_en;
                    ctrl_d.rsvd3 = wdata.rsvd3;
                end
                // with the enable clear bits 11:3 hold
            end
        end
        ctrl_d.wr_en = 1'b0;
        ctrl_d.shadow_sel = SEL_MISC;
    end

    // ------------------------------------------------------------
    // Downshift attempt counter
    // ------------------------------------------------------------
    logic [3:0] fail_cnt_q, fail_cnt_d, limit;
    logic adv_reduced_d, retry_d, mdix_run_d;

    // Code 0..7 maps to a limit of 2..9 attempts
    assign limit = ATTEMPT_BASE + {1'b0, attempt_code};

    // Count failures only while downshift is on
    // A link coming up wins over a failure in the same cycle
    always_comb begin
        fail_cnt_d = fail_cnt_q;
        adv_reduced_d = adv_reduced_q;
        retry_d = 1'b0;
        if (!ctrl_q.downshift_en) begin
            fail_cnt_d = 4'h0;
            adv_reduced_d = 1'b0;
        end else if (link_up) begin
            fail_cnt_d = 4'h0;
        end else if (link_fail) begin
            // A >= test still fires if the limit drops mid-count
            if (fail_cnt_q + 4'h1 >= limit) begin
                fail_cnt_d = 4'h0;
                adv_reduced_d = 1'b1;
                retry_d = 1'b1;
            end else begin
                fail_cnt_d = fail_cnt_q + 4'h1;
            end
        end
        // Forced crossover only matters with negotiation off
        mdix_run_d = an_enabled ? an_mdix : ctrl_q.mdix_force;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Outputs take the next image, so each comes straight from a flop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_q <= CTRL_RST;
            wr_sel_q <= WR_SEL_RST;
            fail_cnt_q <= 4'h0;
            adv_reduced_q <= 1'b0;
            retry_q <= 1'b0;
            mdix_run_q <= 1'b0;
            rdata_q <= 16'(CTRL_RST);
            rd_sel_q <= RD_SEL_RST;
            pkt_rx_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            wr_sel_q <= wr_sel_d;
            fail_cnt_q <= fail_cnt_d;
            adv_reduced_q <= adv_reduced_d;
            retry_q <= retry_d;
            mdix_run_q <= mdix_run_d;
            rdata_q <= 16'(ctrl_d); // Readback tracks the image
            rd_sel_q <= ctrl_d.rd_sel;
            pkt_rx_q <= ctrl_d.pkt_rx;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    // All checks share the one clock and rest during reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_wide_write: assert property (
        hit && wdata.shadow_sel == SEL_MISC && wdata.wr_en
        |=> rdata_q[11:3] == $past(mgmt_wdata[11:3]))
        else $error("enabled write did not load bits 11:3");
    a_narrow_hold: assert property (
        hit && !wdata.wr_en |=> $stable(ctrl_q[11:3]))
        else $error("bits 11:3 changed without write enable");
    a_wr_en_clear: assert property (!rdata_q[WR_EN_BIT])
        else $error("write enable bit read back as one");
    a_sel_always: assert property (
        hit && wdata.shadow_sel == SEL_MISC
        |=> rd_sel_q == $past(mgmt_wdata[14:12]))
        else $error("read selector not loaded");
    a_pkt_dir: assert property (
        hit && wdata.shadow_sel == SEL_MISC && wdata.wr_en
        |=> pkt_rx_q == $past(mgmt_wdata[11]))
        else $error("packet direction not loaded");
    a_mdix_force: assert property (
        !an_enabled ##1 !an_enabled |-> mdix_run_q == $past(ctrl_q.mdix_force))
        else $error("forced crossover not followed");
    a_downshift_off: assert property (
        !ctrl_q.downshift_en |=> !adv_reduced_q && !retry_q)
        else $error("abilities reduced while downshift off");
    a_other_shadow: assert property (
        hit && wdata.shadow_sel != SEL_MISC |=> $stable(ctrl_q))
        else $error("foreign shadow write changed this register");
    a_shadow_sel: assert property (
        hit |=> wr_sel_q == $past(mgmt_wdata[2:0]))
        else $error("shadow select not captured");
    a_limit_hit: assert property (
        ctrl_q.downshift_en && !link_up && link_fail
        && fail_cnt_q == {1'b0, attempt_code} + 4'h1
        |=> retry_q && adv_reduced_q)
        else $error("downshift missed at attempt limit");

    // ------------------------------------------------------------
    // Downshift, crossover and hold checks
    // ------------------------------------------------------------
    // A retry is one pulse, and the count restarts behind it
    a_retry_pulse: assert property (
        retry_q |=> !retry_q)
        else $error("retry pulse lasted more than one cycle");
    a_retry_reduce: assert property (
        retry_q |-> adv_reduced_q)
        else $error("retry without reduced abilities");
    // Failures short of the limit must not start a retry
    a_below_limit: assert property (
        ctrl_q.downshift_en && !link_up && link_fail
        && fail_cnt_q < {1'b0, attempt_code} + 4'h1 |=> !retry_q)
        else $error("retry before the attempt limit");
    a_link_restart: assert property (
        link_up |=> !retry_q)
        else $error("retry while the link was up");
    a_mdix_follow: assert property (
        an_enabled |=> mdix_run_q == $past(an_mdix))
        else $error("crossover ignored the negotiation request");
    // Without a write the readback and shadow select may not move
    a_idle_hold: assert property (
        !hit |=> $stable(rdata_q) && $stable(wr_sel_q))
        else $error("register changed without a write");
    a_image_sel: assert property (rdata_q[2:0] == SEL_MISC)
        else $error("image select bits not 111");
    a_narrow_keep: assert property (
        hit && wdata.shadow_sel == SEL_MISC && !wdata.wr_en
        |=> pkt_rx_q == $past(pkt_rx_q)
        && rd_sel_q == $past(mgmt_wdata[14:12]))
        else $error("narrow write moved a guarded field");

    c_wide_write: cover property (hit && wdata.wr_en
        && wdata.shadow_sel == SEL_MISC);
    c_foreign: cover property (hit && wdata.shadow_sel == SEL_TEST);
    c_retry: cover property (retry_q);
    c_mdix: cover property (!an_enabled && mdix_run_q);
    c_narrow: cover property (hit && !wdata.wr_en
        && wdata.shadow_sel == SEL_MISC);
endmodule : shadowed_phy_misc_control

// File: tb_top.sv
// Self-checking bench for the control register
`timescale 1ns/100ps
module tb_top;
    import misc_ctrl_pkg::*;
    logic clk, rst, mgmt_wr, an_enabled, an_mdix, link_fail, link_up;
    logic pkt_rx_q, mdix_run_q, adv_reduced_q, retry_q;
    logic [4:0] mgmt_devad;
    logic [2:0] wr_sel_q, rd_sel_q, attempt_code, ws;
    logic [15:0] mgmt_addr, mgmt_wdata, rdata_q, img;
    logic [22:0] exp_q[$];
    int error_cnt = 0, total_checks = 0, rcnt = 0, i;
    logic [31:0] seed = 32'h4f55, r;
    mgmt_station_model mgmt_station_model_inst (.clk(clk), .mgmt_wr(mgmt_wr),
        .mgmt_devad(mgmt_devad), .mgmt_addr(mgmt_addr),
        .mgmt_wdata(mgmt_wdata), .rdata_q(rdata_q));
    shadowed_phy_misc_control shadowed_phy_misc_control_inst (.clk(clk),
        .rst(rst), .mgmt_wr(mgmt_wr), .mgmt_devad(mgmt_devad),
        .mgmt_addr(mgmt_addr), .mgmt_wdata(mgmt_wdata), .rdata_q(rdata_q),
        .wr_sel_q(wr_sel_q), .rd_sel_q(rd_sel_q), .pkt_rx_q(pkt_rx_q),
        .mdix_run_q(mdix_run_q), .an_enabled(an_enabled), .an_mdix(an_mdix),
        .link_fail(link_fail), .link_up(link_up),
        .attempt_code(attempt_code), .adv_reduced_q(adv_reduced_q),
        .retry_q(retry_q));
    // ----
    // Helpers
    // ----
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic check(input string nm, input logic [22:0] s, e);
        total_checks++;
        if (s !== e) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic print_verdict();
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : print_verdict
    // Reference image updated, note queued, then the write issued
    task automatic hit(input logic [15:0] d, input logic [4:0] dv, bit m);
        if (m) begin
            d = (img & 16'h05e8) | (d & ~16'h05e8);
            dv = DEVAD_MISC;
        end
        if (dv == DEVAD_MISC) begin
            ws = d[2:0];
            if (d[2:0] == SEL_MISC) begin
                img[14:12] = d[14:12];
                if (d[WR_EN_BIT]) img[11:3] = d[11:3];
            end
        end
        exp_q.push_back({img[14:12], img[11], ws, img});
        if (m) mgmt_station_model_inst.rmw(d);
        else mgmt_station_model_inst.wr(dv, d);
    endtask : hit
    // Result watcher: one note per strobe seen
    always @(posedge clk) begin : watch
        logic w;
        w = mgmt_wr;
        #2 if (w === 1'b1) check("image", {rd_sel_q, pkt_rx_q, wr_sel_q,
            rdata_q}, exp_q.pop_front());
        if (retry_q === 1'b1) rcnt++;
    end
    initial begin
        #20000 error_cnt++;
        print_verdict();
    end
    // Main sequence
    initial begin
        {rst, an_enabled, an_mdix, link_fail, link_up} = 5'h10;
        attempt_code = 3'h0;
        img = 16'h0007;
        ws = 3'h7;
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        check("reset", {rd_sel_q, pkt_rx_q, wr_sel_q, rdata_q}, 23'h070007);
        for (i = 0; i < 8; i++) hit({1'b0, i[2:0], 12'h007}, 5'h07, 0);
        repeat (16) begin
            r = $random(seed);
            hit({r[15:3], r[2] ? 3'h7 : r[2:0]}, r[3] ? 5'h07 : 5'h06, r[4]);
        end
        hit(16'h8207, 5'h07, 0);
        repeat (2) @(posedge clk);
        #1 check("mdix", {22'h0, mdix_run_q}, 23'h1);
        an_enabled = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("mdix_an", {22'h0, mdix_run_q}, 23'h0);
        an_mdix = 1'b1;
        repeat (2) @(posedge clk);
        #1 check("mdix_req", {22'h0, mdix_run_q}, 23'h1);
        hit(16'h8017, 5'h07, 0);
        for (i = 0; i < 8; i++) begin
            attempt_code = i[2:0];
            link_up = 1'b1;
            @(posedge clk);
            #1 link_up = 1'b0;
            link_fail = 1'b1;
            repeat (i + 2) @(posedge clk);
            #1 link_fail = 1'b0;
            check("retry", {21'h0, retry_q, adv_reduced_q}, 23'h3);
        end
        hit(16'h8007, 5'h07, 0);
        link_fail = 1'b1;
        repeat (12) @(posedge clk);
        #1 link_fail = 1'b0;
        check("no_downshift", {adv_reduced_q, 22'(rcnt)}, 23'h8);
        print_verdict();
    end
endmodule : tb_top
